// [rtl/standard_watchdog_enable_control.sv]
// Chosen here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
// Overview of operation
// - While disabled, the fault output stays released high regardless of kicks.
// - Raising timer select with no kicks asserts fault after the timeout.
// - Enable echo output follows the enable input continuously.
// - Disabled by enable: echo low, fault high, so both may be tied.
// - While disabled, kicks and missing kicks are ignored; fault released.
// - After re-enable, wait 150 microseconds before monitoring resumes.
// - Watchdog runs only while timer select is high; low disables it.
// - Disabling through timer select leaves the enable echo unchanged.
// - Capacitor timeout is 77.4 ms per nanofarad plus 55 ms.
// - Fault asserts when kick interval exceeds the selected timeout.
// - After a missed-kick fault, the next good kick releases fault.
`include "wdt_consts.svh"

module standard_watchdog_enable_control #(
  // Timeouts in 10 us ticks; shorten these in simulation.
  parameter logic [`TICKS_WIDTH-1:0] OPEN_TICKS = 26'h0027100,
  parameter logic [`TICKS_WIDTH-1:0] PULLUP_TICKS = 26'h0004E20,
  parameter logic [`TICKS_WIDTH-1:0] CAP_SLOPE_TICKS = 26'h0000306,
  parameter logic [`TICKS_WIDTH-1:0] CAP_BASE_TICKS = 26'h000157C
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM register slave.
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Interrupt.
  output logic irq,
  // Supervised processor and supervisor pins.
  input wire logic kick_input,
  input wire logic enable_in,
  input wire logic timer_select_in,
  input wire wdt_pkg::timing_cfg_type timeout_config_pin,
  // Open-drain fault pin, active low.
  input wire logic fault_out_n_in,
  output logic fault_out_n_out,
  output logic fault_out_n_oe,
  // Enable echo.
  output logic enable_echo_out
);
  import wdt_pkg::*;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [`SYNC_WIDTH-1:0] syncA_reg;
  logic [`SYNC_WIDTH-1:0] syncB_reg;
  logic [`SYNC_WIDTH-1:0] syncC_reg;
  logic [`SYNC_WIDTH-1:0] pinStable_reg;
  logic [`SYNC_WIDTH-1:0] pinStable_next;
  logic [`SYNC_WIDTH-1:0] pinRaw;

  assign pinRaw = {fault_out_n_in, timeout_config_pin, timer_select_in,
                   enable_in, kick_input};

  // Three stages; a bit only moves once stages two and three agree, which
  // rejects single-cycle glitches on the slow board-level pins.
  always_ff @(posedge clk) begin
    if (reset) begin
      syncA_reg <= 6'h00;
      syncB_reg <= 6'h00;
      syncC_reg <= 6'h00;
    end else begin
      syncA_reg <= pinRaw;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `SYNC_WIDTH; g = g + 1) begin : gAgree
      assign pinStable_next[g] = (syncB_reg[g] == syncC_reg[g]) ?
                                 syncC_reg[g] : pinStable_reg[g];
    end
  endgenerate

  // Reset to the benign level: enable high, select low, kick low.
  always_ff @(posedge clk) begin
    if (reset) begin
      pinStable_reg <= `RST_PINS;
    end else begin
      pinStable_reg <= pinStable_next;
    end
  end

  logic kickLevel;
  logic enableLevel;
  logic selectLevel;
  logic faultPinLevel;
  timing_cfg_type cfgLevel;
  assign kickLevel = pinStable_reg[0];
  assign enableLevel = pinStable_reg[1];
  assign selectLevel = pinStable_reg[2];
  assign cfgLevel = timing_cfg_type'(pinStable_reg[4:3]);
  assign faultPinLevel = pinStable_reg[5];

  // ***************************************************************
  // Kick edge and time base
  // ***************************************************************
  logic kickPrev_reg;
  logic kickFall;
  logic [`PRESCALE_WIDTH-1:0] prescale_reg;
  logic [`PRESCALE_WIDTH-1:0] prescale_next;
  logic tick;

  assign kickFall = kickPrev_reg & ~kickLevel;
  assign tick = (prescale_reg == `PRESCALE_WIDTH'(`TICK_CYCLES - 1));
  assign prescale_next = tick ? `PRESCALE_WIDTH'(0) :
                         prescale_reg + `PRESCALE_WIDTH'(1);

  // Free-running 10 us time base; a kick restart may lose under one tick.
  always_ff @(posedge clk) begin
    if (reset) begin
      kickPrev_reg <= 1'b0;
      prescale_reg <= 8'h00;
    end else begin
      kickPrev_reg <= kickLevel;
      prescale_reg <= prescale_next;
    end
  end

  // ***************************************************************
  // Timeout selection
  // ***************************************************************
  logic [`CAP_WIDTH-1:0] cap_reg;
  logic [`TICKS_WIDTH-1:0] capTicks;
  logic [`TICKS_WIDTH-1:0] timeoutTicks;

  // Capacitance is in 0.1 nF units, so 77.4 ms/nF is 774 ticks per unit.
  assign capTicks = `TICKS_WIDTH'(CAP_SLOPE_TICKS *
                    {10'h000, cap_reg} + CAP_BASE_TICKS);
  assign timeoutTicks = (cfgLevel == CFG_CAPACITOR) ? capTicks :
                        (cfgLevel == CFG_PULLUP) ? PULLUP_TICKS :
                        OPEN_TICKS;

  // ***************************************************************
  // Supervisor state machine
  // ***************************************************************
  wdt_state_type state_reg;
  wdt_state_type state_next;
  logic [`STARTUP_WIDTH-1:0] startup_reg;
  logic [`STARTUP_WIDTH-1:0] startup_next;
  logic [`TICKS_WIDTH-1:0] ticks_reg;
  logic [`TICKS_WIDTH-1:0] ticks_next;
  logic active;
  logic startupDone;
  logic expired;

  // Either pin low stops the watchdog.
  assign active = enableLevel & selectLevel;
  assign startupDone =
    (startup_reg == `STARTUP_WIDTH'(`STARTUP_CYCLES - 1));
  assign expired = (ticks_reg >= timeoutTicks);

  always_comb begin
    state_next = state_reg;
    startup_next = startup_reg;
    ticks_next = ticks_reg;
    if (!active) begin
      state_next = DISABLED;
      startup_next = `STARTUP_WIDTH'(0);
      ticks_next = `TICKS_WIDTH'(0);
    end else begin
      unique case (state_reg)
        DISABLED: begin
          state_next = STARTUP;
          startup_next = `STARTUP_WIDTH'(0);
        end
        STARTUP: begin
          startup_next = startup_reg + `STARTUP_WIDTH'(1);
          if (startupDone) begin
            state_next = MONITOR;
            ticks_next = `TICKS_WIDTH'(0);
          end
        end
        MONITOR: begin
          if (kickFall) begin
            ticks_next = `TICKS_WIDTH'(0);
          end else if (expired) begin
            state_next = FAULT;
          end else if (tick) begin
            ticks_next = ticks_reg + `TICKS_WIDTH'(1);
          end
        end
        FAULT: begin
          if (kickFall) begin
            state_next = MONITOR;
            ticks_next = `TICKS_WIDTH'(0);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= DISABLED;
      startup_reg <= 12'h000;
      ticks_reg <= 26'h0000000;
    end else begin
      state_reg <= state_next;
      startup_reg <= startup_next;
      ticks_reg <= ticks_next;
    end
  end

  // ***************************************************************
  // Pin outputs
  // ***************************************************************
  logic faultOe_reg;
  logic echo_reg;
  logic faultDrive_next;

  // Drive low only in the fault state; released (high impedance) otherwise.
  assign faultDrive_next = (state_next == FAULT);

  // The echo tracks only the enable pin, never the select pin, so a
  // select-pin disable does not ripple to parts hung on the echo.
  always_ff @(posedge clk) begin
    if (reset) begin
      faultOe_reg <= 1'b0;
      echo_reg <= 1'b1;
    end else begin
      faultOe_reg <= faultDrive_next;
      echo_reg <= enableLevel;
    end
  end

  assign fault_out_n_oe = faultOe_reg;
  assign enable_echo_out = echo_reg;

  // The open-drain data level is always low; the enable does the work.
  logic faultLow_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      faultLow_reg <= 1'b0;
    end else begin
      faultLow_reg <= 1'b0;
    end
  end
  assign fault_out_n_out = faultLow_reg;

  // ***************************************************************
  // Events and interrupt
  // ***************************************************************
  logic [`EV_WIDTH-1:0] events_reg;
  logic [`EV_WIDTH-1:0] events_next;
  logic [`EV_WIDTH-1:0] mask_reg;
  logic [`EV_WIDTH-1:0] eventHit;
  logic [`EV_WIDTH-1:0] eventClear;
  logic irq_reg;

  logic accept;
  logic writeHit;

  assign eventHit[`EV_FAULT_SET] = (state_next == FAULT) &&
                                   (state_reg != FAULT);
  assign eventHit[`EV_FAULT_CLR] = (state_reg == FAULT) &&
                                   (state_next != FAULT);
  assign eventHit[`EV_KICK] = kickFall && (state_reg == MONITOR);
  assign eventClear = (writeHit && address == `ADDR_IRQ_STATUS) ?
                      writedata[`EV_WIDTH-1:0] : `RST_EVENTS;
  // A new event beats a clear landing in the same cycle.
  assign events_next = (events_reg & ~eventClear) | eventHit;

  always_ff @(posedge clk) begin
    if (reset) begin
      events_reg <= `RST_EVENTS;
      irq_reg <= 1'b0;
    end else begin
      events_reg <= events_next;
      irq_reg <= |(events_next & mask_reg);
    end
  end
  assign irq = irq_reg;

  // ***************************************************************
  // Avalon-MM slave
  // ***************************************************************
  // One wait cycle: request seen with waitrequest high, answered the next.
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdataSel;
  logic [31:0] statusWord;

  assign accept = (read | write) & wait_reg;
  assign writeHit = write & ~wait_reg;
  assign statusWord = {27'h0000000, faultPinLevel, echo_reg,
                       state_reg == MONITOR || state_reg == FAULT,
                       active, state_reg == FAULT};
  assign rdataSel =
    (address == `ADDR_STATUS) ? statusWord :
    (address == `ADDR_IRQ_STATUS) ? {29'h00000000, events_reg} :
    (address == `ADDR_IRQ_MASK) ? {29'h00000000, mask_reg} :
    (address == `ADDR_CAP) ? {16'h0000, cap_reg} :
    (address == `ADDR_TIMEOUT) ? {6'h00, timeoutTicks} : `RST_DATA;

  always_ff @(posedge clk) begin
    if (reset) begin
      wait_reg <= 1'b1;
      rdata_reg <= `RST_DATA;
    end else begin
      wait_reg <= ~accept;
      rdata_reg <= (accept && read) ? rdataSel : `RST_DATA;
    end
  end

  // Writes land on the edge where waitrequest is seen low.
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_reg <= `RST_MASK;
      cap_reg <= `RST_CAP;
    end else begin
      if (writeHit && address == `ADDR_IRQ_MASK) begin
        mask_reg <= writedata[`EV_WIDTH-1:0];
      end
      if (writeHit && address == `ADDR_CAP) begin
        cap_reg <= writedata[`CAP_WIDTH-1:0];
      end
    end
  end

  assign waitrequest = wait_reg;
  assign readdata = rdata_reg;

endmodule // standard_watchdog_enable_control

// [rtl/wdt_consts.svh]
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ***************************************************************
// Register map (byte addresses on the Avalon slave)
// ***************************************************************
`define ADDR_STATUS 5'h00
`define ADDR_IRQ_STATUS 5'h04
`define ADDR_IRQ_MASK 5'h08
`define ADDR_CAP 5'h0C
`define ADDR_TIMEOUT 5'h10

// ***************************************************************
// Field positions
// ***************************************************************
`define ST_FAULT 0
`define ST_ACTIVE 1
`define ST_MONITOR 2
`define ST_ECHO 3
`define ST_PIN 4
`define EV_FAULT_SET 0
`define EV_FAULT_CLR 1
`define EV_KICK 2
`define EV_WIDTH 3
`define CAP_WIDTH 16
`define TICKS_WIDTH 26

// ***************************************************************
// Reset values
// ***************************************************************
`define RST_EVENTS 3'h0
`define RST_MASK 3'h0
`define RST_CAP 16'h0000
`define RST_DATA 32'h00000000
`define RST_PINS 6'h22

// ***************************************************************
// Timing
// ***************************************************************
`define CLK_PERIOD_NS 40
`define TICK_NS 10000
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define STARTUP_NS 150000
`define STARTUP_CYCLES ((`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRESCALE_WIDTH 8
`define STARTUP_WIDTH 12
`define SYNC_WIDTH 6

`endif

// [rtl/wdt_pkg.sv]
package wdt_pkg;

  // Supervisor sequencing states.
  typedef enum logic [1:0] {
    DISABLED,
    STARTUP,
    MONITOR,
    FAULT
  } wdt_state_type;

  // Strapping of the timing-configuration pin.
  typedef enum logic [1:0] {
    CFG_OPEN = 2'h0,
    CFG_PULLUP = 2'h1,
    CFG_CAPACITOR = 2'h2,
    CFG_SPARE = 2'h3
  } timing_cfg_type;

endpackage

// [verification/mcu_model.sv]
`timescale 1ns/1ps
// ********************************************
// Supervised processor kick source
// ********************************************
module mcu_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Kick period in cycles; zero parks the line high.
  input wire logic [15:0] kickPeriod,
  // Kick line.
  output logic kick
);
  logic [15:0] cnt_reg;

  // Low for half a period, so each fall outlasts the pin filter.
  always_ff @(posedge clk) begin
    if (reset || kickPeriod == 16'h0000) begin
      cnt_reg <= 16'h0000;
      kick <= 1'b1;
    end else begin
      cnt_reg <= (cnt_reg >= kickPeriod - 16'h0001) ? 16'h0000
        : cnt_reg + 16'h0001;
      kick <= (cnt_reg < (kickPeriod >> 1));
    end
  end
endmodule // mcu_model

// [verification/wdt_properties.sv]
`timescale 1ns/1ps
// ********************************************
// Port checker
// ********************************************
module wdt_properties #(
  parameter logic [25:0] OPEN_TICKS = 26'h0027100
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Bus handshake.
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // Pins.
  input wire logic kick_input,
  input wire logic enable_in,
  input wire logic timer_select_in,
  input wire wdt_pkg::timing_cfg_type timeout_config_pin,
  input wire logic fault_out_n_oe,
  input wire logic enable_echo_out
);
  import wdt_pkg::*;
  // Start-up, filter delay and the last partial tick fit in the margin.
  // A tighter limit lets the bench reach it before kicks resume.
  localparam int LIM = 3770 + int'(OPEN_TICKS) * 250;
  int actCnt;
  int idleCnt;
  logic kickPrev;

  // Time enabled, and time since the last kick fall while enabled.
  always_ff @(posedge clk) begin
    kickPrev <= kick_input;
    if (reset || !(enable_in && timer_select_in)) begin
      actCnt <= 0;
      idleCnt <= 0;
    end else begin
      actCnt <= (actCnt < LIM) ? actCnt + 1 : actCnt;
      idleCnt <= (kickPrev && !kick_input) ? 0
        : ((idleCnt < LIM) ? idleCnt + 1 : idleCnt);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence reqSeen;
    (read || write) && waitrequest;
  endsequence
  sequence kickInFault;
    fault_out_n_oe ##1 $fell(kick_input);
  endsequence

  // Pin relations; the bus bound is exact, the pin bounds carry margin.
  chk_bus_answer: assert property (reqSeen |=> !waitrequest ##1 waitrequest)
    else $error("Bus answer not exactly one cycle.");
  chk_echo_follows: assert property (enable_in [*8] |-> enable_echo_out)
    else $error("Echo not high with enable high.");
  chk_echo_low: assert property (!enable_in [*8] |->
    !enable_echo_out && !fault_out_n_oe)
    else $error("Disabled by enable but echo or fault wrong.");
  chk_sel_echo: assert property (
    (enable_in && !timer_select_in) [*8] |-> enable_echo_out)
    else $error("Select disable moved the echo.");
  chk_off_released: assert property (!timer_select_in [*8] |->
    !fault_out_n_oe)
    else $error("Fault driven while select low.");
  chk_startup_quiet: assert property (
    actCnt > 8 && actCnt < 3740 |-> !fault_out_n_oe)
    else $error("Fault inside start-up delay.");
  chk_fault_timely: assert property (idleCnt == LIM &&
    timeout_config_pin != CFG_CAPACITOR |-> fault_out_n_oe)
    else $error("No fault after missing kicks.");
  chk_kick_release: assert property (kickInFault |-> ##[1:8] !fault_out_n_oe)
    else $error("Kick did not release fault.");
endmodule // wdt_properties

bind standard_watchdog_enable_control wdt_properties #(
  .OPEN_TICKS(OPEN_TICKS)
) u_props (.clk(clk), .reset(reset), .read(read), .write(write),
  .waitrequest(waitrequest), .kick_input(kick_input),
  .enable_in(enable_in), .timer_select_in(timer_select_in),
  .timeout_config_pin(timeout_config_pin),
  .fault_out_n_oe(fault_out_n_oe), .enable_echo_out(enable_echo_out));

// [verification/standard_watchdog_enable_control_tb_top.sv]
`timescale 1ns/1ps
// ********************************************
// Watchdog bench
// ********************************************
module standard_watchdog_enable_control_tb_top;
  import wdt_pkg::*;
  localparam logic [31:0] OPEN_T = 32'h00000004;
  localparam logic [31:0] PULL_T = 32'h00000002;
  logic clk, reset, read, write, waitrequest, irq, kick, enable_in;
  logic timer_select_in, oe, fOut, echo, faultWire;
  logic [4:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [15:0] kickPeriod, capVal;
  timing_cfg_type cfg;
  int n_mismatch, compares, c;

  // Clock and the pulled-up open-drain wire.
  always #20 clk = ~clk;
  assign faultWire = oe ? 1'b0 : 1'b1;

  standard_watchdog_enable_control #(.OPEN_TICKS(OPEN_T[25:0]),
    .PULLUP_TICKS(PULL_T[25:0]), .CAP_SLOPE_TICKS(26'h0000001),
    .CAP_BASE_TICKS(26'h0000002)) uut (.clk(clk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .kick_input(kick), .enable_in(enable_in),
    .timer_select_in(timer_select_in), .timeout_config_pin(cfg),
    .fault_out_n_in(faultWire), .fault_out_n_out(fOut),
    .fault_out_n_oe(oe), .enable_echo_out(echo));
  mcu_model mcu (.clk(clk), .reset(reset), .kickPeriod(kickPeriod),
    .kick(kick));

  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      @(posedge clk);
      n++;
    end
    check("busAnswer", n, 1);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task test_done;
    $display("Counts: compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Main sequence.
  initial begin
    {clk, read, write, address, writedata, timer_select_in} = '0;
    {reset, enable_in} = 2'b11;
    cfg = CFG_OPEN;
    kickPeriod = 16'h0000;
    c = $urandom(39443);
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    bus(0, 5'h00, 0);
    check("status", rd[4:0], 5'h18);
    bus(0, 5'h08, 0);
    check("maskReset", rd, 0);
    bus(0, 5'h0C, 0);
    check("capReset", rd, 0);
    capVal = 16'($urandom);
    bus(1, 5'h0C, {16'h0000, capVal});
    bus(1, 5'h14, 32'hFFFFFFFF);
    bus(0, 5'h0C, 0);
    check("cap", rd, {16'h0000, capVal});
    bus(0, 5'h14, 0);
    check("unmapped", rd, 0);
    for (int i = 0; i < 4; i++) begin
      cfg <= timing_cfg_type'(i);
      repeat (8) @(posedge clk);
      bus(0, 5'h10, 0);
      check("timeout", rd, (i == 1) ? PULL_T :
        (i == 2) ? {16'h0000, capVal} + 32'h00000002 : OPEN_T);
    end
    cfg <= CFG_OPEN;
    $display("Registers test done.");
    // Missed kicks raise the fault after start-up plus timeout.
    bus(1, 5'h08, 32'h3);
    timer_select_in <= 1'b1;
    c = 0;
    while (faultWire !== 1'b0 && c < 8000) begin
      @(posedge clk);
      c++;
    end
    // The time base runs free, so the first tick may come early.
    check("faultTime", c >= 3750 + (OPEN_T - 1) * 250 &&
      c <= 3760 + OPEN_T * 250, 1);
    repeat (3) @(posedge clk);
    check("irqFault", irq, 1);
    check("faultData", fOut, 0);
    bus(0, 5'h00, 0);
    check("statusFault", rd[4:0], 5'h0F);
    bus(1, 5'h08, 0);
    repeat (2) @(posedge clk);
    check("irqMasked", irq, 0);
    bus(1, 5'h04, 32'h1);
    bus(0, 5'h04, 0);
    check("irqCleared", rd, 0);
    bus(1, 5'h08, 32'h3);
    repeat (400) @(posedge clk);
    $display("Missed kick test done.");
    // Kicks resume at a random period inside the open-pin timeout in use.
    kickPeriod <= 16'(200 + $urandom % 500);
    repeat (4000) @(posedge clk);
    check("released", faultWire, 1);
    check("irqRelease", irq, 1);
    bus(0, 5'h04, 0);
    check("eventsRelease", rd[2:1], 2'b11);
    bus(0, 5'h00, 0);
    check("statusRun", rd[4:0], 5'h1E);
    $display("Resume test done.");
    // Select low: kicks stop, nothing fires, echo untouched.
    kickPeriod <= 16'h0000;
    timer_select_in <= 1'b0;
    repeat (3000) @(posedge clk);
    check("selOffWire", faultWire, 1);
    check("selOffEcho", echo, 1);
    // Enable low: echo low, fault high.
    timer_select_in <= 1'b1;
    enable_in <= 1'b0;
    repeat (3000) @(posedge clk);
    check("enOffWire", faultWire, 1);
    check("enOffEcho", echo, 0);
    bus(0, 5'h00, 0);
    check("statusOff", rd[4:0], 5'h10);
    $display("Disable test done.");
    test_done();
  end

  // Cuts a hang well past the expected run length.
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule // standard_watchdog_enable_control_tb_top
